/* core/acc_defs.svh */
// register offsets, field positions and reset values of the calibration bank
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_CAL_EN_IDX 8'h61
`define ACC_PASS_SEL_IDX 8'h62
`define ACC_REF_CFG_IDX 8'h65
`define ACC_STATUS_IDX 8'h70
`define ACC_FG_BIT 0
`define ACC_BG_BIT 1
`define ACC_FGOS_BIT 2
`define ACC_BGOS_BIT 3
`define ACC_OFFSET_REFERENCE_SELECT_BIT 2
`define ACC_CAL_EN_RST 8'h01
`define ACC_PASS_SEL_RST 8'h01
`define ACC_REF_CFG_RST 8'h01
`define ACC_ADDR_W 10
`endif

/* core/acc_pkg.sv */
// types shared by the calibration configuration bank
package acc_pkg;
  typedef logic [7:0] acc_byte_t;
endpackage

/* core/acc_cal_seq.sv */
// calibration sequencer: clears stored values then runs the foreground pass if selected
`timescale 1ns/10ps
`default_nettype none
module acc_cal_seq
  import acc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // settings
  input wire logic cal_enable,
  input wire logic foreground_cal_run,
  // engine controls
  output logic clear_values_r,
  output logic fg_pass_r,
  output logic fg_done_r
);
  typedef enum logic [1:0] {IDLE, CLEAR, FG, DONE} acc_seq_t;
  acc_seq_t state_r, state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE: state_nxt = cal_enable ? CLEAR : IDLE;
      // stored values always cleared first, fg pass only if selected
      CLEAR: state_nxt = foreground_cal_run ? FG : DONE;
      FG: state_nxt = DONE;
      DONE: state_nxt = DONE;
    endcase
    if (!cal_enable)
      state_nxt = IDLE;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= IDLE;
      clear_values_r <= 1'b0;
      fg_pass_r <= 1'b0;
      fg_done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      clear_values_r <= (state_nxt == CLEAR);
      fg_pass_r <= (state_nxt == FG);
      fg_done_r <= (state_nxt == DONE);
    end
  end
endmodule
`default_nettype wire

/* core/acc_cal_regs.sv */
// calibration configuration register bank with avalon-mm slave
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_cal_regs
  import acc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [`ACC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // calibration engine controls
  output logic cal_run,
  output logic clear_values,
  output logic fg_cal_active,
  output logic fg_offset_cal_active,
  output logic bg_cal_active,
  output logic bg_offset_cal_active,
  output logic offset_ref_spare
);
  logic rst_s1_r, rst_n_r;
  acc_byte_t cal_en_r, pass_sel_r, ref_cfg_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic fg_pass, fg_done;

  // reset released through two flops, asserted asynchronously
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // byte addresses are four times the printed index
  wire [7:0] word_idx = avs_address[`ACC_ADDR_W-1:2];
  wire aligned = (avs_address[1:0] == 2'b00);
  wire hit_en = aligned && (word_idx == `ACC_CAL_EN_IDX);
  wire hit_sel = aligned && (word_idx == `ACC_PASS_SEL_IDX);
  wire hit_ref = aligned && (word_idx == `ACC_REF_CFG_IDX);
  wire hit_sts = aligned && (word_idx == `ACC_STATUS_IDX);
  wire req = (avs_read || avs_write) && !ack_r;
  // a write lands on the edge that ends its waitrequest-low cycle
  wire wr_lane0 = avs_write && ack_r && avs_byteenable[0];
  wire [31:0] rd_mux =
    hit_en ? {24'h000000, cal_en_r} :
    hit_sel ? {24'h000000, pass_sel_r} :
    hit_ref ? {24'h000000, ref_cfg_r} :
    hit_sts ? {29'h00000000, fg_done, fg_pass, clear_values} :
    32'h00000000;

  // one wait cycle per access; ack_r ends it
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cal_en_r <= `ACC_CAL_EN_RST;
      pass_sel_r <= `ACC_PASS_SEL_RST;
      ref_cfg_r <= `ACC_REF_CFG_RST;
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= req;
      if (avs_read && req)
        rdata_r <= rd_mux;
      // all bits stored as written, reserved ones included
      if (wr_lane0 && hit_en)
        cal_en_r <= avs_writedata[7:0];
      if (wr_lane0 && hit_sel)
        pass_sel_r <= avs_writedata[7:0];
      if (wr_lane0 && hit_ref)
        ref_cfg_r <= avs_writedata[7:0];
    end
  end

  assign cal_run = cal_en_r[0];

  acc_cal_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n_r),
    .cal_enable(cal_run),
    .foreground_cal_run(pass_sel_r[`ACC_FG_BIT]),
    .clear_values_r(clear_values),
    .fg_pass_r(fg_pass),
    .fg_done_r(fg_done)
  );

  assign fg_cal_active = fg_pass;
  // offset pass gated by its parent enable
  assign fg_offset_cal_active = fg_pass &&
    pass_sel_r[`ACC_FGOS_BIT] && pass_sel_r[`ACC_FG_BIT];
  assign bg_cal_active = cal_run && fg_done &&
    pass_sel_r[`ACC_BG_BIT];
  assign bg_offset_cal_active = bg_cal_active &&
    pass_sel_r[`ACC_BGOS_BIT];
  // 0: mid-code target, 1: spare converter as reference
  assign offset_ref_spare = ref_cfg_r[`ACC_OFFSET_REFERENCE_SELECT_BIT];
endmodule
`default_nettype wire

/* sim/acc_cal_regs_monitor.sv */
// assertions on the calibration bank's engine outputs
`timescale 1ns/10ps
`default_nettype none
module acc_cal_regs_monitor(
  // watched ports
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cal_run,
  input wire logic clear_values,
  input wire logic fg_cal_active,
  input wire logic fg_offset_cal_active,
  input wire logic bg_cal_active,
  input wire logic bg_offset_cal_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_clear_on_start: assert property ($rose(cal_run) |=> clear_values)
    else $error("no clear after enable");
  a_clear_one_cycle: assert property (clear_values |=> !clear_values)
    else $error("clear phase too long");
  a_fg_after_clear: assert property (fg_cal_active |-> $past(clear_values))
    else $error("fg pass without clear");
  a_clear_not_fg: assert property (clear_values |-> !fg_cal_active)
    else $error("clear and fg overlap");
  a_fgos_needs_fg: assert property (fg_offset_cal_active |-> fg_cal_active)
    else $error("fg offset without fg");
  a_bgos_needs_bg: assert property (bg_offset_cal_active |-> bg_cal_active)
    else $error("bg offset without bg");
  a_bg_needs_run: assert property (bg_cal_active |-> cal_run)
    else $error("bg while disabled");
  a_hold_idle: assert property (!cal_run |=> !clear_values && !fg_cal_active)
    else $error("sequence runs while held");
endmodule
bind acc_cal_regs acc_cal_regs_monitor mon(.ref_clk, .rstn, .cal_run,
  .clear_values, .fg_cal_active, .fg_offset_cal_active, .bg_cal_active,
  .bg_offset_cal_active);
`default_nettype wire

/* sim/acc_host.sv */
// avalon-mm master standing in for host software
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_host(
  // bus
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  output logic [`ACC_ADDR_W-1:0] avs_address = '0,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = '0
);
  // reserved bits are always sent at their reset values by the callers
  task automatic xfer(logic w, logic [9:0] a, logic [7:0] d, output logic t);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    // waitrequest is sampled at the rising edge, where the access completes
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    t = (n >= 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/acc_cal_regs_test.sv */
// self-checking bench for the calibration configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_cal_regs_test;
  import acc_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  wire logic [`ACC_ADDR_W-1:0] adr;
  wire logic rd, wr, wt, run, clr, fg, fgo, bg, bgo, spr;
  wire logic [31:0] wd, rdat;
  int errors = 0;
  int check_count = 0;
  always #10 ref_clk = ~ref_clk;
  acc_host h(.ref_clk(ref_clk), .avs_waitrequest(wt), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd));
  acc_cal_regs uut(.ref_clk(ref_clk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wt),
    .cal_run(run), .clear_values(clr), .fg_cal_active(fg),
    .fg_offset_cal_active(fgo), .bg_cal_active(bg),
    .bg_offset_cal_active(bgo), .offset_ref_spare(spr));
  task automatic test_done;
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      errors++;
    end
  endtask
  task automatic bus(logic w, logic [9:0] a, logic [7:0] d);
    logic t;
    h.xfer(w, a, d, t);
    if (t)
    begin
      errors++;
      test_done();
    end
    if (!w)
      chk("readdata", {24'h0, d}, rdat);
  endtask
  task automatic reset_values;
    bus(0, 10'h184, 8'h01);
    bus(0, 10'h188, 8'h01);
    bus(0, 10'h194, 8'h01);
    bus(0, 10'h200, 8'h00);
  endtask
  task automatic bg_pass;
    bus(1, 10'h184, 8'h00);
    bus(1, 10'h188, 8'h0e);
    bus(1, 10'h194, 8'h05);
    bus(1, 10'h184, 8'h01);
    repeat (4) @(negedge ref_clk);
    chk("outs", 32'hd, {bg, bgo, fgo, spr});
    bus(0, 10'h1c0, 8'h04);
    bus(0, 10'h188, 8'h0e);
    bus(0, 10'h194, 8'h05);
  endtask
  task automatic fg_pass;
    int k;
    bus(1, 10'h184, 8'h00);
    bus(1, 10'h188, 8'h05);
    bus(1, 10'h194, 8'h01);
    bus(1, 10'h184, 8'h01);
    k = 0;
    repeat (8)
    begin
      @(negedge ref_clk);
      k += (fgo === 1'b1);
    end
    chk("fgos_cycles", 1, k);
    chk("bg_spr", 0, {bg, spr});
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset_values();
    bg_pass();
    fg_pass();
    test_done();
  end
endmodule
`default_nettype wire
